// ==== rtl/parallel_flash_program_port.sv ====
// Functional notes
// - While busy, reading last written byte returns it with MSB inverted.
// - During erase, polling reads return all ones with top bit cleared.
// - Polling reference is the last byte loaded before programming starts.
// - Programming mode uses eight-line port as bidirectional command bus.
// - Bytes are strobed by positive pulses on the crystal pin only.
// - Port responds only with select low; ready/busy low whenever busy.
// - Select high resets command state and floats the command bus.
// - Command, address and data bytes sampled on strobe rising edge.
// - Read data driven after fourth strobe until select rises.
// - Session begins with program enable: preamble, opcode, confirmation.
// - Chip erase sets array to ones, user row unless fuse set, unlocks both.
// - Buffer load sets offset; store on rise, increment on fall, wraps.
// - Buffer load clears load flag; buffer kept until a write or erase ends, or session end.
// - Page write takes opcode, high and low address; page from bits 11:5.
// - Select high after address programs only buffered data.
// - Page read presents byte after fourth fall; advances and wraps.
// - User row programming refused while its fuse is set.
// - User signature write uses its own opcode, zero high byte, offset.
// - Status byte carries load, success, inhibit and busy in bits 3:0.
`timescale 1ns/100ps
`default_nettype none
`include "flash_port_regs.svh"
module parallel_flash_program_port #(
  parameter int PAGE_ADDR_W = 7,
  parameter int PAGE_WRITE_CYCLES = `PAGE_WRITE_US * `CLK_MHZ,
  parameter int ERASE_CYCLES = `ERASE_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Programming mode and pins
  input wire logic prog_mode_i,
  input wire logic byte_strobe_pin_i,
  input wire logic select_pin_i,
  input wire logic [7:0] command_bus_i,
  output logic [7:0] command_bus_o,
  output logic command_bus_oe_o,
  output logic ready_busy_pin_o,
  // Configuration and status
  input wire logic user_row_fuse_i,
  input wire logic write_inhibit_flag_i,
  output logic lock_one_o,
  output logic lock_two_o,
  output logic [3:0] status_o
);
  localparam int DEPTH = 32 << PAGE_ADDR_W;
  localparam int AW = PAGE_ADDR_W + 5;
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] stb_sync;
  logic [2:0] sel_sync;
  logic [2:0] mode_sync;
  logic [2:0] inh_sync;
  logic stb_level;
  logic sel_level;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stb_sync <= 3'h0;
      sel_sync <= 3'h7;
      mode_sync <= 3'h0;
      inh_sync <= 3'h7;
      stb_level <= 1'b0;
      sel_level <= 1'b1;
    end else begin
      stb_sync <= {stb_sync[1:0], byte_strobe_pin_i};
      sel_sync <= {sel_sync[1:0], select_pin_i};
      mode_sync <= {mode_sync[1:0], prog_mode_i};
      inh_sync <= {inh_sync[1:0], write_inhibit_flag_i};
      if (stb_sync[1] == stb_sync[2]) begin
        stb_level <= stb_sync[2];
      end
      if (sel_sync[1] == sel_sync[2]) begin
        sel_level <= sel_sync[2];
      end
    end
  end
  wire logic stb_next = (stb_sync[1] == stb_sync[2]) ? stb_sync[2] : stb_level;
  wire logic in_mode = mode_sync[2];
  wire logic inhibit_ok = inh_sync[2];
  wire logic active = in_mode && !sel_level;
  // Erase and writes start as select rises, so busy never begins inside a frame
  wire logic sel_rising = in_mode && sel_sync[2] && !sel_level;
  wire logic stb_rise = active && stb_next && !stb_level;
  wire logic stb_fall = active && !stb_next && stb_level;
  // Bus data is stable around the rise; two-stage latency sits inside hold time
  logic [7:0] bus_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_q <= 8'h00;
    end else begin
      bus_q <= command_bus_i;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Memories
  logic [7:0] code_mem [DEPTH];
  logic [7:0] user_mem [32];
  logic [7:0] page_buf [32];
  logic [31:0] buf_valid;
  //////////////////////////////////////////////////////////////////////////////
  // Command decoder
  flash_port_pkg::cmd_state_e state;
  logic [7:0] opcode;
  logic enabled;
  logic [PAGE_ADDR_W-1:0] page;
  logic [4:0] offset;
  logic reading;
  logic data_seen;
  logic [4:0] last_off;
  logic [7:0] last_byte;
  logic [7:0] poll_ref;
  logic [AW-1:0] poll_addr;
  logic poll_user;
  flash_port_pkg::job_e job;
  flash_port_pkg::job_e pend;
  logic [PAGE_ADDR_W-1:0] job_page;
  logic [31:0] timer;
  logic load_flag;
  logic success;
  wire logic busy = (job != flash_port_pkg::K_NONE);
  function automatic logic is_read_code(input logic [7:0] op);
    return (op == `OP_READ_PAGE) || (op == `OP_READ_USER) || (op == `OP_READ_STATUS);
  endfunction : is_read_code
  wire logic is_read_op = is_read_code(opcode);
  wire logic is_load_op = (opcode == `OP_LOAD_BUFFER) || (opcode == `OP_WRITE_PAGE)
    || (opcode == `OP_WRITE_USER);
  wire logic known_op = is_read_op || is_load_op || (opcode == `OP_CHIP_ERASE);
  wire logic [AW-1:0] rd_addr = {page, offset};
  wire logic [7:0] code_byte = code_mem[rd_addr];
  wire logic [7:0] user_byte = user_mem[offset];
  wire logic [7:0] raw_byte = (opcode == `OP_READ_USER) ? user_byte : code_byte;
  // The user row has no page, so only its offset is compared
  wire logic poll_where = poll_user ? (offset == poll_addr[4:0]) : (rd_addr == poll_addr);
  wire logic poll_hit = busy && poll_where && ((opcode == `OP_READ_USER) == poll_user);
  wire logic [7:0] erase_poll = `ERASED_BYTE & 8'h7f;
  wire logic [7:0] poll_byte = (job == flash_port_pkg::K_ERASE) ? erase_poll
    : {~poll_ref[7], poll_ref[6:0]};
  wire logic [3:0] status_now = {load_flag, success, inhibit_ok, !busy && inhibit_ok};
  wire logic [7:0] read_byte = (opcode == `OP_READ_STATUS) ? {4'h0, status_now}
    : ((job == flash_port_pkg::K_ERASE) || poll_hit) ? poll_byte : raw_byte;
  wire logic [4:0] next_offset = offset + 5'h01;
  wire logic write_op = (opcode == `OP_WRITE_PAGE) || (opcode == `OP_WRITE_USER);
  wire logic user_ok = !user_row_fuse_i;
  wire logic [31:0] job_len = (pend == flash_port_pkg::K_ERASE) ? ERASE_CYCLES : PAGE_WRITE_CYCLES;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= flash_port_pkg::S_PRE;
      opcode <= 8'h00;
      enabled <= 1'b0;
      page <= '0;
      offset <= 5'h00;
      reading <= 1'b0;
      data_seen <= 1'b0;
      last_off <= 5'h00;
      last_byte <= 8'h00;
      pend <= flash_port_pkg::K_NONE;
    end else if (!in_mode) begin
      state <= flash_port_pkg::S_PRE;
      enabled <= 1'b0;
      reading <= 1'b0;
      pend <= flash_port_pkg::K_NONE;
    end else if (sel_level) begin
      state <= flash_port_pkg::S_PRE;
      reading <= 1'b0;
      data_seen <= 1'b0;
      pend <= flash_port_pkg::K_NONE;
    end else begin
      // A pending erase is held here until select rises
      if (stb_rise) begin
        case (state)
          flash_port_pkg::S_PRE: begin
            state <= (bus_q == `OP_PREAMBLE) ? flash_port_pkg::S_OP : flash_port_pkg::S_IGNORE;
          end
          flash_port_pkg::S_OP: begin
            opcode <= bus_q;
            if (bus_q == `OP_ENABLE) begin
              state <= flash_port_pkg::S_CONF;
            end else if (!enabled || (busy && !is_read_code(bus_q))) begin
              state <= flash_port_pkg::S_IGNORE;
            end else if (bus_q == `OP_CHIP_ERASE) begin
              state <= flash_port_pkg::S_IGNORE;
              pend <= flash_port_pkg::K_ERASE;
            end else begin
              state <= flash_port_pkg::S_AHI;
            end
          end
          flash_port_pkg::S_CONF: begin
            if (bus_q == `OP_ENABLE_CONFIRM) begin
              enabled <= 1'b1;
            end
            state <= flash_port_pkg::S_IGNORE;
          end
          flash_port_pkg::S_AHI: begin
            page[PAGE_ADDR_W-1:3] <= bus_q[PAGE_ADDR_W-4:0];
            state <= known_op ? flash_port_pkg::S_ALO : flash_port_pkg::S_IGNORE;
          end
          flash_port_pkg::S_ALO: begin
            if (opcode != `OP_LOAD_BUFFER && opcode != `OP_WRITE_USER) begin
              page[2:0] <= bus_q[7:5];
            end
            offset <= bus_q[4:0];
            state <= flash_port_pkg::S_DATA;
          end
          flash_port_pkg::S_DATA: begin
            if (is_load_op) begin
              last_byte <= bus_q;
              last_off <= offset;
            end
            data_seen <= 1'b1;
          end
          default: begin
            state <= state;
          end
        endcase
      end
      if (stb_fall && state == flash_port_pkg::S_DATA) begin
        if (!data_seen && is_read_op) begin
          reading <= 1'b1;
        end else if (data_seen) begin
          offset <= next_offset;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Buffer, array and programming timer
  wire logic store_byte = stb_rise && state == flash_port_pkg::S_DATA && is_load_op && !busy;
  wire logic launch_write = in_mode && !busy && write_op && state == flash_port_pkg::S_DATA
    && sel_rising;
  wire logic user_launch = opcode == `OP_WRITE_USER;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_valid <= 32'h0;
      job <= flash_port_pkg::K_NONE;
      job_page <= '0;
      timer <= 32'h0;
      load_flag <= 1'b1;
      success <= 1'b1;
      poll_ref <= 8'h00;
      poll_addr <= '0;
      poll_user <= 1'b0;
      lock_one_o <= 1'b1;
      lock_two_o <= 1'b1;
    end else begin
      if (store_byte) begin
        page_buf[offset] <= bus_q;
        buf_valid[offset] <= 1'b1;
        if (opcode == `OP_LOAD_BUFFER) begin
          load_flag <= 1'b0;
        end
      end
      if (!in_mode && !busy) begin
        buf_valid <= 32'h0;
      end
      if (pend == flash_port_pkg::K_ERASE && sel_rising && !busy && inhibit_ok) begin
        job <= flash_port_pkg::K_ERASE;
        timer <= job_len;
        success <= 1'b0;
      end else if (launch_write && inhibit_ok && (!user_launch || user_ok)) begin
        job <= user_launch ? flash_port_pkg::K_USER : flash_port_pkg::K_CODE;
        job_page <= page;
        timer <= PAGE_WRITE_CYCLES;
        success <= 1'b0;
        load_flag <= 1'b1;
        poll_user <= user_launch;
        // The last byte may come from an earlier buffer load
        poll_addr <= {page, last_off};
        poll_ref <= last_byte;
      end else if (busy) begin
        if (timer > 32'h1) begin
          timer <= timer - 32'h1;
        end else begin
          job <= flash_port_pkg::K_NONE;
          success <= inhibit_ok;
          buf_valid <= 32'h0;
          if (job == flash_port_pkg::K_ERASE) begin
            lock_one_o <= 1'b1;
            lock_two_o <= 1'b1;
          end
        end
      end
    end
  end
  // Memory arrays carry no reset; erase rewrites code_mem, and user_mem if user_ok, at the end of the cycle
  wire logic job_done = busy && timer <= 32'h1;
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 32; i++) begin
      if (job_done && job == flash_port_pkg::K_CODE && buf_valid[i]) begin
        code_mem[{job_page, 5'(i)}] <= page_buf[i];
      end
      if (job_done && job == flash_port_pkg::K_USER && buf_valid[i]) begin
        user_mem[i] <= page_buf[i];
      end
      if (job_done && job == flash_port_pkg::K_ERASE && user_ok) begin
        user_mem[i] <= `ERASED_BYTE;
      end
    end
    if (job_done && job == flash_port_pkg::K_ERASE) begin
      for (int j = 0; j < DEPTH; j++) begin
        code_mem[j] <= `ERASED_BYTE;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      command_bus_o <= 8'h00;
      command_bus_oe_o <= 1'b0;
      ready_busy_pin_o <= 1'b0;
      status_o <= 4'h0;
    end else begin
      command_bus_oe_o <= reading && active;
      command_bus_o <= reading ? read_byte : 8'h00;
      ready_busy_pin_o <= !busy && inhibit_ok;
      status_o <= status_now;
    end
  end
endmodule : parallel_flash_program_port
`default_nettype wire

// ==== rtl/flash_port_regs.svh ====
`ifndef FLASH_PORT_REGS_SVH
`define FLASH_PORT_REGS_SVH
`define OP_PREAMBLE 8'haa
`define OP_ENABLE 8'hac
`define OP_ENABLE_CONFIRM 8'h53
`define OP_CHIP_ERASE 8'h8a
`define OP_LOAD_BUFFER 8'h51
`define OP_WRITE_PAGE 8'h50
`define OP_READ_PAGE 8'h30
`define OP_WRITE_USER 8'h52
`define OP_READ_USER 8'h32
`define OP_READ_STATUS 8'h60
`define ERASED_BYTE 8'hff
`define ST_LOAD_BIT 3
`define ST_SUCCESS_BIT 2
`define ST_WRITE_INHIBIT_FLAG_BIT 1
`define ST_BUSY_BIT 0
`define PAGE_WRITE_US 2000
`define ERASE_US 4000
`define CLK_MHZ 200
`endif

// ==== rtl/flash_port_pkg.sv ====
package flash_port_pkg;
  typedef enum logic [2:0] {
    S_PRE = 3'b000,
    S_OP = 3'b001,
    S_AHI = 3'b011,
    S_ALO = 3'b010,
    S_DATA = 3'b110,
    S_CONF = 3'b111,
    S_IGNORE = 3'b101
  } cmd_state_e;
  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_ERASE = 2'b01,
    K_CODE = 2'b11,
    K_USER = 2'b10
  } job_e;
endpackage : flash_port_pkg

// ==== verification/flash_port_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module flash_port_properties #(
  parameter int ERASE_CYCLES = 800000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Pins
  input wire logic prog_mode_i,
  input wire logic byte_strobe_pin_i,
  input wire logic select_pin_i,
  input wire logic command_bus_oe_o,
  input wire logic ready_busy_pin_o,
  // Configuration and status
  input wire logic write_inhibit_flag_i,
  input wire logic lock_one_o,
  input wire logic lock_two_o,
  input wire logic [3:0] status_o
);
  // Slack covers the pin synchronisers around the longest cycle
  localparam int unsigned BUSY_LIMIT = ERASE_CYCLES + 64;
  int unsigned busy_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) busy_cnt <= 0;
    else if (!ready_busy_pin_o && write_inhibit_flag_i && prog_mode_i) busy_cnt <= busy_cnt + 1;
    else busy_cnt <= 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_sel_idle;
    select_pin_i[*8];
  endsequence
  sequence s_read_held;
    (!select_pin_i && prog_mode_i)[*6];
  endsequence
  property p_sel_float; s_sel_idle |-> !command_bus_oe_o; endproperty
  a_sel_float: assert property (p_sel_float) else $error("bus driven with select high");
  property p_mode_float; (!prog_mode_i)[*8] |-> !command_bus_oe_o; endproperty
  a_mode_float: assert property (p_mode_float) else $error("bus driven outside session");
  property p_oe_start;
    $rose(command_bus_oe_o) |-> !select_pin_i && !byte_strobe_pin_i;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("read drive not after strobe fall");
  property p_oe_hold; s_read_held ##0 command_bus_oe_o |=> command_bus_oe_o; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("read drive dropped early");
  property p_inhibit;
    (!write_inhibit_flag_i)[*8] |-> !ready_busy_pin_o && status_o[1:0] == 2'h0;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit not reflected");
  property p_busy_cause;
    $fell(ready_busy_pin_o) && write_inhibit_flag_i |-> select_pin_i;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy began inside a frame");
  property p_busy_bound; busy_cnt <= BUSY_LIMIT; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
  property p_unlocked; lock_one_o && lock_two_o; endproperty
  a_unlocked: assert property (p_unlocked) else $error("lock bit cleared");
endmodule : flash_port_properties
bind parallel_flash_program_port flash_port_properties #(.ERASE_CYCLES(ERASE_CYCLES)) chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .prog_mode_i(prog_mode_i),
  .byte_strobe_pin_i(byte_strobe_pin_i), .select_pin_i(select_pin_i),
  .command_bus_oe_o(command_bus_oe_o), .ready_busy_pin_o(ready_busy_pin_o),
  .write_inhibit_flag_i(write_inhibit_flag_i), .lock_one_o(lock_one_o),
  .lock_two_o(lock_two_o), .status_o(status_o));
`default_nettype wire

// ==== verification/flash_programmer_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module flash_programmer_model (
  // Clock
  input wire logic clk_i,
  // Pins toward the device
  output logic prog_mode_o,
  output logic byte_strobe_o,
  output logic select_o,
  output logic [7:0] bus_o
);
  initial begin
    prog_mode_o = 1'b0;
    byte_strobe_o = 1'b0;
    select_o = 1'b1;
    bus_o = 8'h00;
  end
  task automatic session();
    repeat (20) @(posedge clk_i);
    prog_mode_o <= 1'b1;
    repeat (20) @(posedge clk_i);
  endtask : session
  task automatic end_session();
    prog_mode_o <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask : end_session
  task automatic open_cmd();
    @(posedge clk_i);
    select_o <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask : open_cmd
  // Mode 0 drives, 1 drives the complement late in the high phase, 2 leaves the bus value unchanged
  task automatic pulse(input logic [7:0] b, input int m);
    if (m < 2) bus_o <= b;
    repeat (4) @(posedge clk_i);
    byte_strobe_o <= 1'b1;
    repeat (12) @(posedge clk_i);
    if (m == 1) bus_o <= ~b;
    repeat (4) @(posedge clk_i);
    byte_strobe_o <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask : pulse
  task automatic close_cmd();
    repeat (8) @(posedge clk_i);
    select_o <= 1'b1;
    bus_o <= ~bus_o;
    repeat (16) @(posedge clk_i);
  endtask : close_cmd
endmodule : flash_programmer_model
`default_nettype wire

// ==== verification/tb_parallel_flash_program_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_parallel_flash_program_port;
  // Short cycles keep the run small
  localparam int CYC = 600;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic fuse = 1'b0;
  logic inhibit_n = 1'b1;
  logic prog_mode, strobe, select, oe, rdy;
  logic [7:0] prog_bus, dev_bus, bus;
  logic [3:0] status;
  int error_cnt = 0;
  int check_count = 0;
  assign bus = oe ? dev_bus : prog_bus;
  always #2.5 clk_i = ~clk_i;
  parallel_flash_program_port #(.PAGE_WRITE_CYCLES(CYC), .ERASE_CYCLES(CYC)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .prog_mode_i(prog_mode),
    .byte_strobe_pin_i(strobe), .select_pin_i(select), .command_bus_i(bus),
    .command_bus_o(dev_bus), .command_bus_oe_o(oe), .ready_busy_pin_o(rdy),
    .user_row_fuse_i(fuse), .write_inhibit_flag_i(inhibit_n),
    .lock_one_o(), .lock_two_o(), .status_o(status));
  flash_programmer_model prog (.clk_i(clk_i), .prog_mode_o(prog_mode),
    .byte_strobe_o(strobe), .select_o(select), .bus_o(prog_bus));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_ready();
    int n;
    for (n = 0; n < 3000 && rdy !== 1'b1; n++) @(posedge clk_i);
    if (rdy !== 1'b1) begin
      $display("wrong value at %0t: ready %h expected %h", $time, rdy, 1'b1);
      error_cnt++;
      report_and_stop();
    end
  endtask : wait_ready
  task automatic head(input logic [7:0] op, input logic [15:0] a, input int m);
    prog.open_cmd();
    prog.pulse(8'haa, 0);
    prog.pulse(op, 0);
    prog.pulse(a[15:8], 0);
    prog.pulse(a[7:0], m);
  endtask : head
  task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1,
                    input bit two);
    head(8'h30, a, 1);
    chk(bus, e0);
    prog.pulse(8'h00, 2);
    if (two) chk(bus, e1);
    prog.close_cmd();
    chk({7'h0, oe}, 8'h00);
  endtask : rd
  task automatic rd_one(input logic [7:0] op, input logic [15:0] a, input logic [7:0] e);
    head(op, a, 1);
    chk(bus, e);
    prog.close_cmd();
  endtask : rd_one
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_enable();
    prog.open_cmd();
    prog.pulse(8'haa, 0);
    prog.pulse(8'hac, 0);
    prog.pulse(8'h53, 0);
    prog.close_cmd();
    chk({7'h0, rdy}, 8'h01);
  endtask : t_enable
  task automatic t_erase();
    prog.open_cmd();
    prog.pulse(8'haa, 0);
    prog.pulse(8'h8a, 0);
    prog.close_cmd();
    chk({7'h0, rdy}, 8'h00);
    rd(16'h0000, 8'h7f, 8'h7f, 1);
    wait_ready();
    rd(16'h0fff, 8'hff, 8'hff, 1);
  endtask : t_erase
  // Two bytes straddle the page end, so the last one lands at offset 0
  task automatic t_write_wrap();
    head(8'h50, 16'h013f, 0);
    prog.pulse(8'h11, 0);
    prog.pulse(8'h5a, 0);
    prog.close_cmd();
    chk({7'h0, rdy}, 8'h00);
    rd(16'h0120, 8'hda, 8'h00, 0);
    wait_ready();
    rd(16'h013f, 8'h11, 8'h5a, 1);
    chk({7'h0, status[2]}, 8'h01);
  endtask : t_write_wrap
  task automatic t_load_write();
    head(8'h51, 16'h0005, 0);
    prog.pulse(8'h3c, 0);
    prog.close_cmd();
    chk({7'h0, status[3]}, 8'h00);
    head(8'h50, 16'h0045, 0);
    prog.close_cmd();
    wait_ready();
    chk({7'h0, status[3]}, 8'h01);
    rd(16'h0045, 8'h3c, 8'hff, 1);
  endtask : t_load_write
  task automatic t_refuse();
    fuse <= 1'b1;
    head(8'h52, 16'h0000, 0);
    prog.pulse(8'h77, 0);
    prog.close_cmd();
    chk({7'h0, rdy}, 8'h01);
    inhibit_n <= 1'b0;
    repeat (16) @(posedge clk_i);
    chk({4'h0, status}, 8'h0c);
    chk({7'h0, rdy}, 8'h00);
    inhibit_n <= 1'b1;
    repeat (16) @(posedge clk_i);
    chk({7'h0, rdy}, 8'h01);
  endtask : t_refuse
  task automatic t_user();
    head(8'h52, 16'h0003, 0);
    prog.pulse(8'h96, 0);
    prog.close_cmd();
    rd_one(8'h32, 16'h0003, 8'h16);
    wait_ready();
    rd_one(8'h32, 16'h0003, 8'h96);
    rd_one(8'h60, 16'h0000, 8'h0f);
  endtask : t_user
  // Leaving the session drops the enable and the refused user byte
  task automatic t_session();
    prog.end_session();
    prog.session();
    head(8'h30, 16'h0045, 1);
    chk({7'h0, oe}, 8'h00);
    prog.close_cmd();
    t_enable();
    rd(16'h0045, 8'h3c, 8'hff, 1);
    head(8'h50, 16'h0000, 0);
    prog.close_cmd();
    wait_ready();
    rd(16'h0000, 8'hff, 8'hff, 1);
  endtask : t_session
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    prog.session();
    t_enable();
    t_erase();
    t_write_wrap();
    t_load_write();
    t_user();
    t_refuse();
    t_session();
    report_and_stop();
  end
endmodule : tb_parallel_flash_program_port
`default_nettype wire
